// *** flash_protect_and_page_program.sv ***
`timescale 1ns/1ps
`include "flash_protect_map.svh"

module flash_protect_and_page_program
    import flash_protect_pkg::*;
#(
    parameter int unsigned EP_CYCLES = `PAGE_EP_CYCLES
) (
    // Core clock and reset
    input  wire logic          clk_in,
    input  wire logic          rst_in,
    // Serial link from the host
    input  wire logic          sck_in,
    input  wire logic          cs_n_in,
    input  wire logic          si_in,
    // Device pins and configuration
    input  wire logic          wp_n_in,
    input  wire logic          binary_page_in,
    input  wire sector_marks_t sector_marks_in,
    // Array side
    output array_cmd_s         array_cmd_out,
    // Status
    output status_s            status_out,
    output logic               prog_refused_out,
    output logic               prot_reg_locked_out
);

    // ======================================================================
    // Link domain: serial shift and frame decode

    logic [2:0]  bit_cnt_reg;
    logic [2:0]  byte_cnt_reg;
    logic [7:0]  shift_reg;
    logic [7:0]  opcode_reg;
    logic [23:0] addr_reg;
    logic [8:0]  wr_ptr_reg;
    logic        seq_ok_reg;
    frame_kind_e kind_reg;
    logic [7:0]  byte_now;
    logic        byte_done;
    logic [23:0] addr_full;
    logic [8:0]  start_off;
    logic [8:0]  sck_last;
    logic        busy_sck_meta_reg;
    logic        busy_sck_reg;
    logic        mode_sck_meta_reg;
    logic        mode_sck_reg;
    logic [7:0]  buf_mem [0:`BUF_DEPTH-1];

    assign byte_now  = {shift_reg[6:0], si_in};
    assign byte_done = (bit_cnt_reg == 3'h7);
    assign addr_full = {addr_reg[23:8], byte_now};
    assign sck_last  = mode_sck_reg ? `BUF_LAST_256 : `BUF_LAST_264;

    // Start offset by page mode; an offset past the buffer restarts at zero
    always_comb begin
        if (mode_sck_reg) begin
            start_off = {1'b0, addr_full[7:0]};
        end else begin
            start_off = addr_full[8:0];
        end
        if (start_off > sck_last) begin
            start_off = 9'h000;
        end
    end

    // Busy and page mode into the link domain
    always_ff @(posedge sck_in) begin
        busy_sck_meta_reg <= status_out.busy;
        busy_sck_reg      <= busy_sck_meta_reg;
        mode_sck_meta_reg <= binary_page_in;
        mode_sck_reg      <= mode_sck_meta_reg;
    end

    // Bit and byte counters restart whenever chip select is high
    always_ff @(posedge sck_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            bit_cnt_reg  <= 3'h0;
            byte_cnt_reg <= 3'h0;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (byte_done && byte_cnt_reg != 3'h4) begin
                byte_cnt_reg <= byte_cnt_reg + 3'h1;
            end
        end
    end

    // Serial input shift, MSB first
    always_ff @(posedge sck_in) begin
        shift_reg <= byte_now;
    end

    // Opcode and address capture
    always_ff @(posedge sck_in) begin
        if (!cs_n_in && byte_done) begin
            case (byte_cnt_reg)
                3'h0: begin
                    opcode_reg <= byte_now;
                end
                3'h1: begin
                    addr_reg[23:16] <= byte_now;
                end
                3'h2: begin
                    addr_reg[15:8] <= byte_now;
                end
                3'h3: begin
                    addr_reg[7:0] <= byte_now;
                end
                default: begin
                    addr_reg <= addr_reg;
                end
            endcase
        end
    end

    // Frame kind; only a complete, matching frame leaves a non-empty result
    always_ff @(posedge sck_in or posedge rst_in) begin
        if (rst_in) begin
            kind_reg   <= FRAME_NONE;
            seq_ok_reg <= 1'b0;
        end else if (!cs_n_in) begin
            if (bit_cnt_reg == 3'h0 && byte_cnt_reg == 3'h0) begin
                kind_reg <= FRAME_NONE;
            end
            if (byte_done) begin
                case (byte_cnt_reg)
                    3'h0: begin
                        seq_ok_reg <= (byte_now == `SEQ_BYTE1);
                    end
                    3'h1: begin
                        seq_ok_reg <= seq_ok_reg && (byte_now == `SEQ_BYTE2);
                    end
                    3'h2: begin
                        seq_ok_reg <= seq_ok_reg && (byte_now == `SEQ_BYTE3);
                    end
                    3'h3: begin
                        // Program frames are dropped while the array is busy
                        if (opcode_reg == `OP_PROG_THRU_BUF && !busy_sck_reg) begin
                            kind_reg <= FRAME_PROGRAM;
                        end else if (seq_ok_reg && byte_now == `SEQ_ENABLE) begin
                            kind_reg <= FRAME_ENABLE;
                        end else if (seq_ok_reg && byte_now == `SEQ_DISABLE) begin
                            kind_reg <= FRAME_DISABLE;
                        end
                    end
                    default: begin
                        // Trailing bytes spoil a protection sequence
                        if (kind_reg != FRAME_PROGRAM) begin
                            kind_reg <= FRAME_NONE;
                        end
                    end
                endcase
            end
        end
    end

    // Buffer fill with wrap at the last byte
    always_ff @(posedge sck_in) begin
        if (!cs_n_in && byte_done) begin
            if (byte_cnt_reg == 3'h3) begin
                wr_ptr_reg <= start_off;
            end else if (byte_cnt_reg == 3'h4 && kind_reg == FRAME_PROGRAM) begin
                buf_mem[wr_ptr_reg] <= byte_now;
                if (wr_ptr_reg >= sck_last) begin
                    wr_ptr_reg <= 9'h000;
                end else begin
                    wr_ptr_reg <= wr_ptr_reg + 9'h001;
                end
            end
        end
    end

    // ======================================================================
    // Core domain: synchronisers

    logic cs_meta_reg;
    logic cs_sync_reg;
    logic cs_prev_reg;
    logic cs_rise;
    logic wp_meta_reg;
    logic wp_sync_reg;
    logic mode_meta_reg;
    logic mode_reg;

    // Chip select edge; frame results are stable once it is high
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cs_meta_reg <= 1'b1;
            cs_sync_reg <= 1'b1;
            cs_prev_reg <= 1'b1;
        end else begin
            cs_meta_reg <= cs_n_in;
            cs_sync_reg <= cs_meta_reg;
            cs_prev_reg <= cs_sync_reg;
        end
    end

    assign cs_rise = cs_sync_reg && !cs_prev_reg;

    // Write-protect pin and page mode; idle level is deasserted
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wp_meta_reg   <= 1'b1;
            wp_sync_reg   <= 1'b1;
            mode_meta_reg <= 1'b0;
            mode_reg      <= 1'b0;
        end else begin
            wp_meta_reg   <= wp_n_in;
            wp_sync_reg   <= wp_meta_reg;
            mode_meta_reg <= binary_page_in;
            mode_reg      <= mode_meta_reg;
        end
    end

    // ======================================================================
    // Write-protect glitch filter

    localparam logic [15:0] FILT_LEN = 16'(`LOCK_FILTER_CYCLES);

    logic [15:0] filt_cnt_reg;
    logic        wp_filt_n_reg;

    // A level must hold for the whole filter length before it is accepted
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            filt_cnt_reg  <= 16'h0000;
            wp_filt_n_reg <= 1'b1;
        end else if (wp_sync_reg == wp_filt_n_reg) begin
            filt_cnt_reg <= 16'h0000;
        end else if (filt_cnt_reg >= FILT_LEN) begin
            filt_cnt_reg  <= 16'h0000;
            wp_filt_n_reg <= wp_sync_reg;
        end else begin
            filt_cnt_reg <= filt_cnt_reg + 16'h0001;
        end
    end

    // ======================================================================
    // Software protection state

    logic sw_en_reg;
    logic wp_active;
    logic prot_on;

    assign wp_active = !wp_filt_n_reg;
    assign prot_on   = sw_en_reg || wp_active;

    // Cleared on reset; enable sticks through pin activity
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sw_en_reg <= 1'b0;
        end else if (cs_rise && kind_reg == FRAME_ENABLE) begin
            sw_en_reg <= 1'b1;
        end else if (cs_rise && kind_reg == FRAME_DISABLE && !wp_active) begin
            sw_en_reg <= 1'b0;
        end
    end

    // ======================================================================
    // Target page, sector and protection check

    logic [9:0] tgt_page;
    logic [2:0] tgt_sector;
    logic       sector_marked;

    // Page bits by page mode
    always_comb begin
        if (mode_reg) begin
            tgt_page = addr_reg[17:8];
        end else begin
            tgt_page = addr_reg[18:9];
        end
    end

    assign tgt_sector = tgt_page[9:7];

    // Sector 0 splits into pages 0-7 and 8-127
    always_comb begin
        if (tgt_sector != 3'h0) begin
            sector_marked = &sector_marks_in[tgt_sector];
        end else if (tgt_page[9:3] == 7'h00) begin
            sector_marked = &sector_marks_in[0][7:6];
        end else begin
            sector_marked = &sector_marks_in[0][5:4];
        end
    end

    // ======================================================================
    // Self-timed erase and program sequencer

    prog_state_e state_reg;
    logic [9:0]  page_reg;
    logic [8:0]  col_reg;
    logic [8:0]  col_last_reg;
    logic [31:0] ep_cnt_reg;
    logic        prog_hit;
    logic        prog_start;

    // A refused frame must not even flash busy
    assign prog_hit   = cs_rise && kind_reg == FRAME_PROGRAM && state_reg == PROG_IDLE;
    assign prog_start = prog_hit && !(prot_on && sector_marked);

    // Erase first, then stream the buffer, then hold busy for the cycle time
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_reg    <= PROG_IDLE;
            page_reg     <= 10'h000;
            col_reg      <= 9'h000;
            col_last_reg <= `BUF_LAST_264;
            ep_cnt_reg   <= 32'h0;
        end else begin
            case (state_reg)
                PROG_IDLE: begin
                    ep_cnt_reg <= 32'h0;
                    if (prog_start) begin
                        state_reg    <= PROG_ERASE;
                        page_reg     <= tgt_page;
                        col_last_reg <= mode_reg ? `BUF_LAST_256 : `BUF_LAST_264;
                    end
                end
                PROG_ERASE: begin
                    state_reg  <= PROG_WRITE;
                    col_reg    <= 9'h000;
                    ep_cnt_reg <= ep_cnt_reg + 32'h1;
                end
                PROG_WRITE: begin
                    ep_cnt_reg <= ep_cnt_reg + 32'h1;
                    if (col_reg == col_last_reg) begin
                        state_reg <= PROG_WAIT;
                    end else begin
                        col_reg <= col_reg + 9'h001;
                    end
                end
                PROG_WAIT: begin
                    ep_cnt_reg <= ep_cnt_reg + 32'h1;
                    if (ep_cnt_reg >= EP_CYCLES) begin
                        state_reg <= PROG_IDLE;
                    end
                end
                default: begin
                    state_reg <= PROG_IDLE;
                end
            endcase
        end
    end

    // ======================================================================
    // Registered outputs

    // Array commands; buffer is quiet while busy so the read is safe
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            array_cmd_out <= '0;
        end else begin
            array_cmd_out.erase            <= (state_reg == PROG_ERASE);
            array_cmd_out.write            <= (state_reg == PROG_WRITE);
            array_cmd_out.page_select_bits <= page_reg;
            array_cmd_out.column           <= col_reg;
            array_cmd_out.data             <= buf_mem[col_reg];
        end
    end

    // Status and protection indications
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            status_out          <= '0;
            prog_refused_out    <= 1'b0;
            prot_reg_locked_out <= 1'b0;
        end else begin
            status_out.busy         <= (state_reg != PROG_IDLE) || prog_start;
            status_out.prot_enabled <= prot_on;
            status_out.wp_active    <= wp_active;
            prog_refused_out        <= prog_hit && prot_on && sector_marked;
            prot_reg_locked_out     <= wp_active;
        end
    end

endmodule // flash_protect_and_page_program

// *** flash_protect_map.svh ***
`ifndef FLASH_PROTECT_MAP_SVH
`define FLASH_PROTECT_MAP_SVH
// Function
// - Opcode 82H then three address bytes starts program through buffer.
// - 264-byte pages: five spare bits, 10 page bits, nine buffer offset bits.
// - 256-byte pages: six spare bits, 10 page bits, eight buffer offset bits.
// - Data bytes fill buffer from start offset, wrapping to location zero.
// - Chip select rising edge erases addressed page then writes buffer into it.
// - Busy reported throughout the self-timed erase and program cycle.
// - Sequence 3DH 2AH 7FH A9H enables protection after chip select rises.
// - Sequence 3DH 2AH 7FH 9AH disables protection after chip select rises.
// - Disable sequence ignored while write-protect pin is asserted low.
// - Write-protect input reads deasserted when left unconnected; the design has no pull-up, and only reset loads its synchronisers high.
// - Software protection state is volatile, disabled after power-up.
// - Protected sectors come from the nonvolatile per-sector settings.
// - With protection on, program to a marked sector is refused.
// - Pin asserted blocks changes to settings register and marked sectors.
// - Pin assertion enables protection within the assert delay.
// - Pin release without enable command drops protection within release delay.
// - Enable command before or during assertion keeps protection after release.
// - Write-protect input is filtered against short glitches.
// - Status shows whether protection is enabled by either method.
// - Settings: FFH protects a sector; sector 0 bits 7:6 for 0a, 5:4 for 0b.

// ==========================================================================
// Command bytes
`define OP_PROG_THRU_BUF   8'h82
`define SEQ_BYTE1          8'h3d
`define SEQ_BYTE2          8'h2a
`define SEQ_BYTE3          8'h7f
`define SEQ_ENABLE         8'ha9
`define SEQ_DISABLE        8'h9a

// ==========================================================================
// Buffer geometry
`define BUF_LAST_264       9'h107
`define BUF_LAST_256       9'h0ff
`define BUF_DEPTH          264

// ==========================================================================
// Timing, core clock 200 MHz
`define CLK_MHZ                   200
`define PAGE_ERASE_PROGRAM_TIME_US 4000
`define PAGE_EP_CYCLES            (`PAGE_ERASE_PROGRAM_TIME_US * `CLK_MHZ)
`define LOCK_ASSERT_DELAY_NS      1000
`define LOCK_RELEASE_DELAY_NS     1000
// Filter length: shorter of the two delays, less the synchroniser stages
`define LOCK_FILTER_CYCLES        ((`LOCK_ASSERT_DELAY_NS * `CLK_MHZ) / 1000 - 4)
`endif

// *** flash_protect_pkg.sv ***
package flash_protect_pkg;

    // Decoded result of one chip-select frame
    typedef enum logic [1:0] {
        FRAME_NONE    = 2'b00,
        FRAME_PROGRAM = 2'b01,
        FRAME_ENABLE  = 2'b10,
        FRAME_DISABLE = 2'b11
    } frame_kind_e;

    // Page program sequencer
    typedef enum logic [1:0] {
        PROG_IDLE  = 2'b00,
        PROG_ERASE = 2'b01,
        PROG_WRITE = 2'b10,
        PROG_WAIT  = 2'b11
    } prog_state_e;

    // Per-sector settings, byte n for sector n
    typedef logic [7:0][7:0] sector_marks_t;

    // Commands to the main array
    typedef struct packed {
        logic       erase;
        logic       write;
        logic [9:0] page_select_bits;
        logic [8:0] column;
        logic [7:0] data;
    } array_cmd_s;

    // Status indication
    typedef struct packed {
        logic busy;
        logic prot_enabled;
        logic wp_active;
    } status_s;

endpackage

// *** flash_protect_chk.sv ***
`timescale 1ns/1ps
// ==========================================================
// Checker on the top-level ports
module flash_protect_chk
    import flash_protect_pkg::*;
#(
    parameter int unsigned EP_CYCLES = 600
) (
    // Clock and reset
    input wire logic          clk_in,
    input wire logic          rst_in,
    // Serial link and pins
    input wire logic          sck_in,
    input wire logic          cs_n_in,
    input wire logic          si_in,
    input wire logic          wp_n_in,
    input wire logic          binary_page_in,
    input wire sector_marks_t sector_marks_in,
    // Design outputs
    input wire array_cmd_s    array_cmd_out,
    input wire status_s       status_out,
    input wire logic          prog_refused_out,
    input wire logic          prot_reg_locked_out
);
    logic [7:0]  cs_hist_reg;
    logic [19:0] busy_cnt_reg;
    logic [9:0]  wr_cnt_reg;
    logic [9:0]  wp_low_reg;

    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // Raw select history; a frame end reaches the core late
    always_ff @(posedge clk_in) begin
        cs_hist_reg <= rst_in ? 8'hff : {cs_hist_reg[6:0], cs_n_in};
    end
    // Length of the current busy period
    always_ff @(posedge clk_in) begin
        busy_cnt_reg <= (rst_in || !status_out.busy) ? 20'h0 : busy_cnt_reg + 20'h1;
    end
    // Write pulses since the last erase
    always_ff @(posedge clk_in) begin
        if (rst_in || array_cmd_out.erase) wr_cnt_reg <= 10'h0;
        else if (array_cmd_out.write) wr_cnt_reg <= wr_cnt_reg + 10'h1;
    end
    // Run of low pin samples, saturating so it never wraps
    always_ff @(posedge clk_in) begin
        if (rst_in || wp_n_in) wp_low_reg <= 10'h0;
        else if (wp_low_reg != 10'h3ff) wp_low_reg <= wp_low_reg + 10'h1;
    end

    // ==========================================================
    // Assertions
    a_busy_min: assert property (
        $fell(status_out.busy) |-> busy_cnt_reg >= EP_CYCLES) else $error("busy too short");
    a_busy_max: assert property (
        status_out.busy |-> busy_cnt_reg < EP_CYCLES + 16) else $error("busy too long");
    a_page_writes: assert property (
        $fell(status_out.busy) |-> wr_cnt_reg == ($past(binary_page_in, 2) ? 10'h100 : 10'h108))
        else $error("wrong write count");
    a_erase_pulse: assert property (
        array_cmd_out.erase |-> status_out.busy ##1 !array_cmd_out.erase)
        else $error("erase not a busy pulse");
    a_erase_start: assert property (
        $rose(status_out.busy) |-> ##[1:3] array_cmd_out.erase) else $error("no erase");
    a_write_busy: assert property (
        array_cmd_out.write |-> status_out.busy && !array_cmd_out.erase)
        else $error("write outside cycle");
    a_column_step: assert property (
        array_cmd_out.write && $past(array_cmd_out.write) |->
        array_cmd_out.column == $past(array_cmd_out.column) + 9'h1) else $error("column skip");
    a_refuse_idle: assert property (
        prog_refused_out |-> !status_out.busy ##1 !status_out.busy) else $error("refused ran");
    a_prot_rise: assert property (
        $rose(status_out.prot_enabled) |-> status_out.wp_active || cs_hist_reg != 8'hff)
        else $error("protection rose uncaused");
    a_prot_fall: assert property (
        $fell(status_out.prot_enabled) |-> !status_out.wp_active)
        else $error("protection fell with pin");
    a_pin_filter: assert property (
        $rose(status_out.wp_active) |-> wp_low_reg >= 10'h0c0) else $error("glitch passed");
    a_lock_prot: assert property (
        $rose(prot_reg_locked_out) |-> ##[0:2] status_out.prot_enabled)
        else $error("lock without protection");

    // Main scenarios reached
    c_program: cover property ($rose(status_out.busy));
    c_refused: cover property (prog_refused_out);
    c_pin_on:  cover property ($rose(status_out.wp_active));
    c_prot_off: cover property ($fell(status_out.prot_enabled));
endmodule // flash_protect_chk

bind flash_protect_and_page_program flash_protect_chk #(.EP_CYCLES(EP_CYCLES)) i_chk (
    .clk_in(clk_in), .rst_in(rst_in), .sck_in(sck_in), .cs_n_in(cs_n_in),
    .si_in(si_in), .wp_n_in(wp_n_in), .binary_page_in(binary_page_in),
    .sector_marks_in(sector_marks_in), .array_cmd_out(array_cmd_out),
    .status_out(status_out), .prog_refused_out(prog_refused_out),
    .prot_reg_locked_out(prot_reg_locked_out)
);

// *** spi_host_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// Host side of the serial link, mode 0
module spi_host_model #(
    parameter int HALF_NS = 24
) (
    // Serial link to the device
    output logic sck_out,
    output logic cs_n_out,
    output logic si_out
);
    logic [7:0] tx_q [$];

    // Idle: clock parked low, device deselected
    initial begin
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        si_out = 1'b0;
    end

    // One frame, MSB first; clock runs only while selected
    task automatic frame();
        cs_n_out = 1'b0;
        foreach (tx_q[i]) begin
            for (int b = 7; b >= 0; b--) begin
                si_out = tx_q[i][b];
                #(HALF_NS);
                sck_out = 1'b1;
                #(HALF_NS);
                sck_out = 1'b0;
            end
        end
        #(HALF_NS);
        cs_n_out = 1'b1;
        si_out = ~si_out; // Released line shows no stale bit
        tx_q.delete();
    endtask
endmodule // spi_host_model

// *** test_flash_protect_and_page_program.sv ***
`timescale 1ns/1ps
// ==========================================================
// Bench top
module test_flash_protect_and_page_program;
    import flash_protect_pkg::*;
    localparam int unsigned EP = 600;

    logic          clk_in = 1'b0;
    logic          rst_in = 1'b1;
    logic          sck;
    logic          cs_n;
    logic          si;
    logic          wp_n_in = 1'b1;
    logic          binary_page_in = 1'b0;
    sector_marks_t sector_marks_in = 64'h0;
    array_cmd_s    array_cmd_out;
    status_s       status_out;
    logic          prog_refused_out;
    logic          prot_reg_locked_out;
    int            n_errors = 0;
    int            total_checks = 0;

    // 200 MHz core clock
    always #2.5 clk_in = ~clk_in;

    spi_host_model i_host (.sck_out(sck), .cs_n_out(cs_n), .si_out(si));

    flash_protect_and_page_program #(.EP_CYCLES(EP)) i_dut (
        .clk_in(clk_in), .rst_in(rst_in), .sck_in(sck), .cs_n_in(cs_n), .si_in(si),
        .wp_n_in(wp_n_in), .binary_page_in(binary_page_in),
        .sector_marks_in(sector_marks_in), .array_cmd_out(array_cmd_out),
        .status_out(status_out), .prog_refused_out(prog_refused_out),
        .prot_reg_locked_out(prot_reg_locked_out)
    );

    // ==========================================================
    // Helpers
    task automatic check(input logic good, input string msg);
        total_checks++;
        if (good !== 1'b1) begin
            n_errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    // Protection sequence, n of its four bytes sent
    task automatic prot_cmd(input logic [7:0] last, input int n, input logic exp);
        logic [7:0] seq [4];
        seq = '{8'h3d, 8'h2a, 8'h7f, last};
        for (int k = 0; k < n; k++) i_host.tx_q.push_back(seq[k]);
        i_host.frame();
        tick(12);
        check(status_out.prot_enabled === exp, "protection state");
    endtask

    // Bounded wait for the filtered pin level
    task automatic wait_wp(input logic lvl);
        int k;
        for (k = 0; k < 210 && status_out.wp_active !== lvl; k++) tick(1);
        if (k == 210) begin
            check(1'b0, "filtered pin timeout");
            report_and_stop();
        end
    endtask

    // Program through buffer; nb data bytes from offset
    task automatic run_prog(input logic [9:0] pg, input logic [8:0] off, input int nb,
                            input logic ok);
        logic [7:0]  exp [264];
        logic        vld [264];
        logic [23:0] adr;
        int          len, k, nw, ne, nr;
        len = binary_page_in ? 256 : 264;
        adr = binary_page_in ? {6'h00, pg, off[7:0]} : {5'h00, pg, off};
        nw = 0;
        ne = 0;
        nr = 0;
        i_host.tx_q = '{8'h82, adr[23:16], adr[15:8], adr[7:0]};
        for (k = 0; k < len; k++) vld[k] = 1'b0;
        for (k = 0; k < nb; k++) begin
            exp[(off + k) % len] = 8'(k) ^ 8'h5a;
            vld[(off + k) % len] = 1'b1;
            i_host.tx_q.push_back(8'(k) ^ 8'h5a);
        end
        i_host.frame();
        for (k = 0; k < EP + 60; k++) begin
            tick(1);
            if (k > 30 && status_out.busy !== 1'b1) break;
            if (prog_refused_out === 1'b1) nr++;
            if (array_cmd_out.erase === 1'b1) ne++;
            if (array_cmd_out.write === 1'b1) begin
                nw++;
                check(array_cmd_out.page_select_bits === pg, "page");
                if (vld[array_cmd_out.column])
                    check(array_cmd_out.data === exp[array_cmd_out.column], "data");
            end
        end
        if (status_out.busy === 1'b1) begin
            check(1'b0, "busy timeout");
            report_and_stop();
        end
        check(ne == (ok ? 1 : 0), "erase count");
        check(nw == (ok ? len : 0), "write count");
        check(nr == (ok ? 0 : 1), "refusal pulse");
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        check(status_out.prot_enabled === 1'b0, "protection after reset");
        check(status_out.busy === 1'b0, "busy after reset");
    endtask

    task automatic t_programs();
        run_prog(10'h3ff, 9'h105, 5, 1'b1);
        binary_page_in = 1'b1;
        run_prog(10'h155, 9'h0fe, 4, 1'b1);
        binary_page_in = 1'b0;
    endtask

    task automatic t_soft_prot();
        prot_cmd(8'ha9, 4, 1'b1);
        prot_cmd(8'h9a, 3, 1'b1);
        prot_cmd(8'h55, 4, 1'b1);
        prot_cmd(8'h9a, 4, 1'b0);
        prot_cmd(8'h55, 4, 1'b0);
    endtask

    task automatic t_sectors();
        sector_marks_in[3] = 8'hff;
        sector_marks_in[0] = 8'hc0;
        run_prog(10'h180, 9'h000, 1, 1'b1);
        prot_cmd(8'ha9, 4, 1'b1);
        run_prog(10'h180, 9'h000, 1, 1'b0);
        run_prog(10'h002, 9'h000, 1, 1'b0);
        run_prog(10'h008, 9'h000, 1, 1'b1);
        prot_cmd(8'h9a, 4, 1'b0);
    endtask

    task automatic t_pin_lock();
        wp_n_in = 1'b0;
        wait_wp(1'b1);
        check(status_out.prot_enabled === 1'b1, "pin protection");
        check(prot_reg_locked_out === 1'b1, "settings lock");
        run_prog(10'h180, 9'h000, 1, 1'b0);
        prot_cmd(8'h9a, 4, 1'b1);
        wp_n_in = 1'b1;
        wait_wp(1'b0);
        tick(8);
        check(status_out.prot_enabled === 1'b0, "protection kept");
        check(prot_reg_locked_out === 1'b0, "settings unlock");
    endtask

    task automatic t_pin_kept();
        wp_n_in = 1'b0;
        wait_wp(1'b1);
        prot_cmd(8'ha9, 4, 1'b1);
        prot_cmd(8'h9a, 4, 1'b1);
        wp_n_in = 1'b1;
        wait_wp(1'b0);
        tick(8);
        check(status_out.prot_enabled === 1'b1, "protection lost");
        prot_cmd(8'h9a, 4, 1'b0);
    endtask

    task automatic t_glitch();
        int k, seen;
        seen = 0;
        wp_n_in = 1'b0;
        tick(40);
        wp_n_in = 1'b1;
        for (k = 0; k < 240; k++) begin
            tick(1);
            if (status_out.wp_active === 1'b1) seen++;
        end
        check(seen == 0, "glitch passed filter");
    endtask

    // Main sequence; pin left high as when unconnected
    initial begin
        tick(4);
        rst_in = 1'b0;
        tick(4);
        t_reset();
        t_programs();
        t_soft_prot();
        t_sectors();
        t_pin_lock();
        t_pin_kept();
        t_glitch();
        report_and_stop();
    end
endmodule // test_flash_protect_and_page_program
